// ==== core/tsmar_consts.svh ====
// register map, field positions, reset values and timing of the sensor core
// assumes a 100 MHz system clock; included by the package only
`ifndef TSMAR_CONSTS_SVH
`define TSMAR_CONSTS_SVH
// register addresses
`define TSMAR_ADDR_STATUS 3'h0
`define TSMAR_ADDR_CONFIG 3'h1
`define TSMAR_ADDR_TEMP 3'h2
`define TSMAR_ADDR_IDENT 3'h3
`define TSMAR_ADDR_CRIT 3'h4
`define TSMAR_ADDR_HYST 3'h5
`define TSMAR_ADDR_HIGH 3'h6
`define TSMAR_ADDR_LOW 3'h7
// reset values
`define TSMAR_RST_STATUS 8'h80
`define TSMAR_RST_CONFIG 8'h00
`define TSMAR_RST_TEMP 16'h0000
`define TSMAR_RST_CRIT 16'h4980
`define TSMAR_RST_HYST 8'h05
`define TSMAR_RST_HIGH 16'h2000
`define TSMAR_RST_LOW 16'h0500
// configuration fields
`define TSMAR_CFG_FQ_MSB 1
`define TSMAR_CFG_FQ_LSB 0
`define TSMAR_CFG_CT_POL 2
`define TSMAR_CFG_LIM_POL 3
`define TSMAR_CFG_CMP 4
`define TSMAR_CFG_MODE_MSB 6
`define TSMAR_CFG_MODE_LSB 5
`define TSMAR_CFG_RES16 7
// status fields
`define TSMAR_ST_LOW 4
`define TSMAR_ST_HIGH 5
`define TSMAR_ST_CRIT 6
`define TSMAR_ST_RDY 7
// command byte fields
`define TSMAR_CMD_RD 6
`define TSMAR_CMD_ADDR_MSB 5
`define TSMAR_CMD_ADDR_LSB 3
// hysteresis: one degree is 128 codes of the 16-bit word
`define TSMAR_HYST_SHIFT 7
// timing
`define TSMAR_CLK_MHZ 100
`define TSMAR_T_CONV_CONT_MS 240
`define TSMAR_T_CONV_1SPS_MS 60
`define TSMAR_T_IDLE_1SPS_MS 940
`define TSMAR_T_WAKE_MS 1
`define TSMAR_CYC_CONV_CONT (`TSMAR_T_CONV_CONT_MS * 1000 * `TSMAR_CLK_MHZ)
`define TSMAR_CYC_CONV_1SPS (`TSMAR_T_CONV_1SPS_MS * 1000 * `TSMAR_CLK_MHZ)
`define TSMAR_CYC_IDLE_1SPS (`TSMAR_T_IDLE_1SPS_MS * 1000 * `TSMAR_CLK_MHZ)
`define TSMAR_CYC_WAKE (`TSMAR_T_WAKE_MS * 1000 * `TSMAR_CLK_MHZ)
`endif

// ==== core/tsmar_pkg.sv ====
// types shared by the sensor core and its serial front end
// assumes tsmar_consts.svh on the include path
`default_nettype none
package tsmar_pkg;
`include "tsmar_consts.svh"

    typedef enum logic [1:0] {
        MODE_CONT = 2'b00,
        MODE_ONESHOT = 2'b01,
        MODE_1SPS = 2'b10,
        MODE_SHDN = 2'b11
    } tsmar_mode_t;

    typedef enum logic [3:0] {
        SEQ_CONV = 4'b0001,
        SEQ_IDLE = 4'b0010,
        SEQ_SHDN = 4'b0100,
        SEQ_WAKE = 4'b1000
    } tsmar_seq_t;

    typedef enum logic [2:0] {
        PH_CMD = 3'b001,
        PH_RD = 3'b010,
        PH_WR = 3'b100
    } tsmar_phase_t;

    typedef struct packed {
        logic sclk_m, sclk_s, sclk_p, cs_m, cs_s, mosi_m, mosi_s;
        tsmar_phase_t phase;
        logic [3:0] bitcnt;
        logic [15:0] sh_in;
        logic [2:0] addr;
        logic wide;
        logic [16:0] sh_out;
        logic rd_req, wr_req;
        logic [15:0] wr_data;
    } tsmar_fe_st_t;

    typedef struct packed {
        tsmar_seq_t seq;
        logic [31:0] cnt;
        logic [7:0] cfg;
        logic [15:0] temp, crit;
        logic [7:0] hyst;
        logic [15:0] high, low;
        logic fl_crit, fl_high, fl_low, rdy_n;
        logic [2:0] fq_cnt;
        logic ct_act, lim_act, ct_oe, lim_oe;
    } tsmar_core_st_t;

    // 16-bit registers are the result and the three limits
    function automatic logic tsmar_is_wide(input logic [2:0] a);
        return (a == `TSMAR_ADDR_TEMP) || (a == `TSMAR_ADDR_CRIT) ||
               (a == `TSMAR_ADDR_HIGH) || (a == `TSMAR_ADDR_LOW);
    endfunction : tsmar_is_wide
endpackage : tsmar_pkg
`default_nettype wire

// ==== core/tsmar_regbus_if.sv ====
// register access strobes between serial front end and sensor core
// assumes both ends on i_clk_sys
`default_nettype none
interface tsmar_regbus_if;
    logic [2:0] addr;
    logic rd_req;
    logic [15:0] rd_data;
    logic wr_req;
    logic [15:0] wr_data;
    modport fe (output addr, output rd_req, output wr_req, output wr_data, input rd_data);
    modport core (input addr, input rd_req, input wr_req, input wr_data, output rd_data);
endinterface : tsmar_regbus_if
`default_nettype wire

// ==== core/tsmar_spi_fe.sv ====
// serial front end: samples the serial pins on the system clock, frames commands
// assumes mode 3 (clock idles high), msb first, clock well below a quarter of i_clk_sys
`default_nettype none
module tsmar_spi_fe
    import tsmar_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    tsmar_regbus_if.fe bus
);
    tsmar_fe_st_t s_q;
    tsmar_fe_st_t s_d;
    logic rise;
    logic fall;
    logic last;
    logic [7:0] cmd;
    logic [15:0] shifted;

    assign rise = s_q.sclk_s & ~s_q.sclk_p;
    assign fall = ~s_q.sclk_s & s_q.sclk_p;
    assign last = s_q.bitcnt == (s_q.wide ? 4'hF : 4'h7);
    assign cmd = {s_q.sh_in[6:0], s_q.mosi_s};
    assign shifted = {s_q.sh_in[14:0], s_q.mosi_s};

    // ========================================
    // framing
    always_comb begin
        s_d = s_q;
        s_d.sclk_m = i_sclk;
        s_d.sclk_s = s_q.sclk_m;
        s_d.sclk_p = s_q.sclk_s;
        s_d.cs_m = i_cs_n;
        s_d.cs_s = s_q.cs_m;
        s_d.mosi_m = i_mosi;
        s_d.mosi_s = s_q.mosi_m;
        s_d.rd_req = 1'b0;
        s_d.wr_req = 1'b0;
        if (s_q.cs_s) begin
            s_d.phase = PH_CMD;
            s_d.bitcnt = 4'h0;
        end else begin
            // capture the addressed value the cycle it is requested
            if (s_q.rd_req) begin
                s_d.sh_out = s_q.wide ? {1'b0, bus.rd_data} : {1'b0, bus.rd_data[7:0], 8'h00};
            end
            case (s_q.phase)
                PH_CMD: if (rise) begin
                    s_d.sh_in = shifted;
                    s_d.bitcnt = 4'(s_q.bitcnt + 4'h1);
                    if (s_q.bitcnt == 4'h7) begin
                        s_d.bitcnt = 4'h0;
                        s_d.addr = cmd[`TSMAR_CMD_ADDR_MSB:`TSMAR_CMD_ADDR_LSB];
                        s_d.wide = tsmar_is_wide(cmd[`TSMAR_CMD_ADDR_MSB:`TSMAR_CMD_ADDR_LSB]);
                        if (cmd[`TSMAR_CMD_RD]) begin
                            s_d.phase = PH_RD;
                            s_d.rd_req = 1'b1;
                        end else begin
                            s_d.phase = PH_WR;
                        end
                    end
                end
                PH_WR: if (rise) begin
                    s_d.sh_in = shifted;
                    s_d.bitcnt = 4'(s_q.bitcnt + 4'h1);
                    if (last) begin
                        s_d.wr_req = 1'b1;
                        s_d.wr_data = s_q.wide ? shifted : {8'h00, shifted[7:0]};
                        s_d.phase = PH_CMD;
                        s_d.bitcnt = 4'h0;
                    end
                end
                PH_RD: begin
                    if (fall) begin
                        s_d.sh_out = {s_q.sh_out[15:0], 1'b0};
                    end
                    if (rise) begin
                        s_d.bitcnt = 4'(s_q.bitcnt + 4'h1);
                        if (last) begin
                            s_d.phase = PH_CMD;
                            s_d.bitcnt = 4'h0;
                        end
                    end
                end
                default: s_d.phase = PH_CMD;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '{sclk_m: 1'b1, sclk_s: 1'b1, sclk_p: 1'b1, cs_m: 1'b1, cs_s: 1'b1,
                     phase: PH_CMD, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_miso = s_q.sh_out[16];
    assign o_miso_oe = (s_q.phase == PH_RD) & ~s_q.cs_s;
    assign bus.addr = s_q.addr;
    assign bus.rd_req = s_q.rd_req;
    assign bus.wr_req = s_q.wr_req;
    assign bus.wr_data = s_q.wr_data;
endmodule : tsmar_spi_fe
`default_nettype wire

// ==== core/tsmar_top.sv ====
// temperature sensor core: conversion sequencing, limit alarms, register map
// assumes i_temp_code is a settled 16-bit code from the modulator on i_clk_sys
`default_nettype none
module tsmar_top
    import tsmar_pkg::*;
#(
    parameter int unsigned CONV_CONT_CYC = `TSMAR_CYC_CONV_CONT,
    parameter int unsigned CONV_1SPS_CYC = `TSMAR_CYC_CONV_1SPS,
    parameter int unsigned IDLE_1SPS_CYC = `TSMAR_CYC_IDLE_1SPS,
    parameter int unsigned WAKE_CYC = `TSMAR_CYC_WAKE,
    // arbitrary value
    parameter logic [7:0] IDENT_VALUE = 8'h5A
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire logic [15:0] i_temp_code,
    output logic o_miso,
    output logic o_miso_oe,
    output logic o_critical_alarm_out,
    output logic o_critical_alarm_out_oe,
    output logic o_limit_alarm_out,
    output logic o_limit_alarm_out_oe
);
    localparam logic [7:0] ST_RST = `TSMAR_RST_STATUS;
    localparam tsmar_core_st_t CORE_RST = '{
        seq: SEQ_CONV,
        cnt: 32'h0,
        cfg: `TSMAR_RST_CONFIG,
        temp: `TSMAR_RST_TEMP,
        crit: `TSMAR_RST_CRIT,
        hyst: `TSMAR_RST_HYST,
        high: `TSMAR_RST_HIGH,
        low: `TSMAR_RST_LOW,
        fl_crit: ST_RST[`TSMAR_ST_CRIT],
        fl_high: ST_RST[`TSMAR_ST_HIGH],
        fl_low: ST_RST[`TSMAR_ST_LOW],
        rdy_n: ST_RST[`TSMAR_ST_RDY],
        fq_cnt: 3'h0,
        ct_act: 1'b0,
        lim_act: 1'b0,
        ct_oe: 1'b0,
        lim_oe: 1'b0
    };

    tsmar_regbus_if bus ();
    tsmar_core_st_t s_q;
    tsmar_core_st_t s_d;

    // ========================================
    // serial front end
    tsmar_spi_fe u_fe (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_mosi(i_mosi),
        .o_miso(o_miso),
        .o_miso_oe(o_miso_oe),
        .bus(bus)
    );

    // ========================================
    // access decode
    tsmar_mode_t cur_mode;
    tsmar_mode_t new_mode;
    logic res16;
    logic cfg_wr;
    logic sts_rd;
    logic tmp_rd;
    logic [31:0] conv_last;

    assign cur_mode = tsmar_mode_t'(s_q.cfg[`TSMAR_CFG_MODE_MSB:`TSMAR_CFG_MODE_LSB]);
    assign new_mode = tsmar_mode_t'(bus.wr_data[`TSMAR_CFG_MODE_MSB:`TSMAR_CFG_MODE_LSB]);
    assign res16 = s_q.cfg[`TSMAR_CFG_RES16];
    assign cfg_wr = bus.wr_req && (bus.addr == `TSMAR_ADDR_CONFIG);
    assign sts_rd = bus.rd_req && (bus.addr == `TSMAR_ADDR_STATUS);
    assign tmp_rd = bus.rd_req && (bus.addr == `TSMAR_ADDR_TEMP);
    assign conv_last = (cur_mode == MODE_1SPS) ? 32'(CONV_1SPS_CYC - 1) :
                       32'(CONV_CONT_CYC - 1);

    // ========================================
    // limit comparison
    // sign-extended value, low bits dropped at 13-bit resolution
    function automatic logic signed [16:0] tsmar_val(input logic [15:0] v, input logic r16);
        return r16 ? $signed({v[15], v}) : $signed({v[15], v[15:3], 3'b000});
    endfunction : tsmar_val

    logic signed [16:0] smp;
    logic signed [16:0] lim_c;
    logic signed [16:0] lim_h;
    logic signed [16:0] lim_l;
    logic signed [16:0] hy;
    logic flt_c;
    logic flt_h;
    logic flt_l;
    logic any_flt;
    logic clr_c;
    logic clr_h;
    logic clr_l;
    logic [2:0] need;
    logic [2:0] fq_next;
    logic qual;
    logic conv_done;
    logic [15:0] result;

    assign smp = tsmar_val(i_temp_code, res16);
    assign lim_c = tsmar_val(s_q.crit, res16);
    assign lim_h = tsmar_val(s_q.high, res16);
    assign lim_l = tsmar_val(s_q.low, res16);
    assign hy = $signed({2'b00, s_q.hyst, 7'h00});
    assign flt_c = smp > lim_c;
    assign flt_h = smp > lim_h;
    assign flt_l = smp < lim_l;
    assign any_flt = flt_c | flt_h | flt_l;
    assign clr_c = smp < (lim_c - hy);
    assign clr_h = smp < (lim_h - hy);
    assign clr_l = smp > (lim_l + hy);
    // fault queue depth one to four
    assign need = 3'({1'b0, s_q.cfg[`TSMAR_CFG_FQ_MSB:`TSMAR_CFG_FQ_LSB]} + 3'h1);
    assign fq_next = !any_flt ? 3'h0 :
                     (s_q.fq_cnt >= need) ? need : 3'(s_q.fq_cnt + 3'h1);
    assign qual = any_flt && (fq_next == need);
    // full 16-bit code, or 13-bit code with limit flags below it
    assign result = res16 ? i_temp_code :
                    {i_temp_code[15:3], flt_c, flt_h, flt_l};

    // ========================================
    // sequencer and registers
    always_comb begin
        s_d = s_q;
        conv_done = 1'b0;
        case (s_q.seq)
            SEQ_CONV: begin
                if (s_q.cnt >= conv_last) begin
                    conv_done = 1'b1;
                    s_d.cnt = 32'h0;
                    case (cur_mode)
                        MODE_CONT: s_d.seq = SEQ_CONV;
                        MODE_1SPS: s_d.seq = SEQ_IDLE;
                        default: s_d.seq = SEQ_SHDN;
                    endcase
                end else begin
                    s_d.cnt = 32'(s_q.cnt + 32'h1);
                end
            end
            SEQ_IDLE: begin
                if (s_q.cnt >= 32'(IDLE_1SPS_CYC - 1)) begin
                    s_d.seq = SEQ_CONV;
                    s_d.cnt = 32'h0;
                end else begin
                    s_d.cnt = 32'(s_q.cnt + 32'h1);
                end
            end
            SEQ_WAKE: begin
                if (s_q.cnt >= 32'(WAKE_CYC - 1)) begin
                    s_d.seq = SEQ_CONV;
                    s_d.cnt = 32'h0;
                end else begin
                    s_d.cnt = 32'(s_q.cnt + 32'h1);
                end
            end
            SEQ_SHDN: s_d.cnt = 32'h0;
            default: begin
                s_d.seq = SEQ_CONV;
                s_d.cnt = 32'h0;
            end
        endcase

        // writable registers only; others ignore writes
        if (bus.wr_req) begin
            if (bus.addr == `TSMAR_ADDR_CONFIG) begin
                s_d.cfg = bus.wr_data[7:0];
            end else if (bus.addr == `TSMAR_ADDR_CRIT) begin
                s_d.crit = bus.wr_data;
            end else if (bus.addr == `TSMAR_ADDR_HYST) begin
                s_d.hyst = bus.wr_data[7:0];
            end else if (bus.addr == `TSMAR_ADDR_HIGH) begin
                s_d.high = bus.wr_data;
            end else if (bus.addr == `TSMAR_ADDR_LOW) begin
                s_d.low = bus.wr_data;
            end
        end

        // mode writes steer the sequencer
        if (cfg_wr) begin
            if (new_mode == MODE_SHDN) begin
                s_d.seq = SEQ_SHDN;
                s_d.cnt = 32'h0;
            end else if (s_q.seq == SEQ_SHDN) begin
                s_d.seq = SEQ_WAKE;
                s_d.cnt = 32'h0;
            end else if (new_mode != cur_mode || new_mode == MODE_ONESHOT) begin
                s_d.seq = SEQ_CONV;
                s_d.cnt = 32'h0;
            end
        end

        // result and fault queue, only at the end of a conversion
        if (conv_done) begin
            s_d.temp = result;
            s_d.fq_cnt = fq_next;
        end

        // status flags: a new fault wins over a same-cycle clear
        s_d.fl_low = (s_q.fl_low & ~sts_rd & ~(conv_done & clr_l)) |
                     (conv_done & flt_l);
        s_d.fl_high = (s_q.fl_high & ~sts_rd & ~(conv_done & clr_h)) |
                      (conv_done & flt_h);
        s_d.fl_crit = (s_q.fl_crit & ~sts_rd & ~(conv_done & clr_c)) |
                      (conv_done & flt_c);

        // ready, active low; a new result wins over a same-cycle read
        if (conv_done) begin
            s_d.rdy_n = 1'b0;
        end else if (tmp_rd) begin
            s_d.rdy_n = 1'b1;
        end else if (cfg_wr && (cur_mode == MODE_ONESHOT || cur_mode == MODE_1SPS)) begin
            s_d.rdy_n = 1'b1;
        end

        // alarms: comparator mode follows hysteresis, interrupt mode clears on any read
        if (s_q.cfg[`TSMAR_CFG_CMP]) begin
            s_d.ct_act = (s_q.ct_act & ~(conv_done & clr_c)) |
                         (conv_done & qual & flt_c);
            s_d.lim_act = (s_q.lim_act & ~(conv_done & clr_h & clr_l)) |
                          (conv_done & qual & (flt_h | flt_l));
        end else begin
            s_d.ct_act = (s_q.ct_act & ~bus.rd_req) | (conv_done & qual & flt_c);
            s_d.lim_act = (s_q.lim_act & ~bus.rd_req) |
                          (conv_done & qual & (flt_h | flt_l));
        end

        // open-drain: pull low whenever the pin level must be low
        s_d.ct_oe = s_d.ct_act ^ s_d.cfg[`TSMAR_CFG_CT_POL];
        s_d.lim_oe = s_d.lim_act ^ s_d.cfg[`TSMAR_CFG_LIM_POL];
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= CORE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================
    // read data
    always_comb begin
        if (bus.addr == `TSMAR_ADDR_STATUS) begin
            bus.rd_data = {8'h00, s_q.rdy_n, s_q.fl_crit, s_q.fl_high, s_q.fl_low, 4'h0};
        end else if (bus.addr == `TSMAR_ADDR_CONFIG) begin
            bus.rd_data = {8'h00, s_q.cfg};
        end else if (bus.addr == `TSMAR_ADDR_TEMP) begin
            bus.rd_data = s_q.temp;
        end else if (bus.addr == `TSMAR_ADDR_IDENT) begin
            bus.rd_data = {8'h00, IDENT_VALUE};
        end else if (bus.addr == `TSMAR_ADDR_CRIT) begin
            bus.rd_data = s_q.crit;
        end else if (bus.addr == `TSMAR_ADDR_HYST) begin
            bus.rd_data = {8'h00, s_q.hyst};
        end else if (bus.addr == `TSMAR_ADDR_HIGH) begin
            bus.rd_data = s_q.high;
        end else begin
            bus.rd_data = s_q.low;
        end
    end

    // ========================================
    // pins
    assign o_critical_alarm_out = 1'b0;
    assign o_critical_alarm_out_oe = s_q.ct_oe;
    assign o_limit_alarm_out = 1'b0;
    assign o_limit_alarm_out_oe = s_q.lim_oe;
endmodule : tsmar_top
`default_nettype wire

// ==== tb/tb.sv ====
// testbench: register map, result format, shutdown and alarm queue
// assumes conversions shortened to 40 cycles and the host model on the pins
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 40;
    localparam logic [7:0] WIDE = 8'hD4;
    localparam logic [7:0] IDENT = 8'h3C; // arbitrary value
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sclk, cs_n, mosi, miso, miso_oe, ct, ct_oe, lim, lim_oe;
    logic [15:0] code = 16'h1000;
    logic [15:0] rx, w;
    int deg;
    logic [15:0] regs [8] = '{16'h80, 16'h0, 16'h0, 16'(IDENT), 16'h4980, 16'h5, 16'h2000, 16'h500};
    int num_errors = 0;
    int checks = 0;
    always #5 clk = ~clk;
    tsmar_top #(.CONV_CONT_CYC(CONV), .CONV_1SPS_CYC(20), .IDLE_1SPS_CYC(30), .WAKE_CYC(10),
        .IDENT_VALUE(IDENT)) i_tsmar_top (.i_clk_sys(clk), .i_nrst(nrst), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_mosi(mosi), .i_temp_code(code), .o_miso(miso), .o_miso_oe(miso_oe),
        .o_critical_alarm_out(ct), .o_critical_alarm_out_oe(ct_oe), .o_limit_alarm_out(lim),
        .o_limit_alarm_out_oe(lim_oe));
    tsmar_host i_tsmar_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
        .i_miso(miso_oe ? miso : 1'hZ));
    // ====================
    // model and bus tasks
    function automatic logic [15:0] fmt(input logic [15:0] c);
        int t;
        t = $signed(c[15:3]);
        if (regs[1][7]) return c;
        return {c[15:3], t > $signed(regs[4][15:3]), t > $signed(regs[6][15:3]),
            t < $signed(regs[7][15:3])};
    endfunction : fmt
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc
    task automatic acc(input logic r, input logic [2:0] a, input logic [15:0] d);
        logic [7:0] cmd;
        cmd = {1'b0, r, a, 3'h0};
        if (!r && !(a inside {3'h0, 3'h2, 3'h3})) regs[a] = WIDE[a] ? d : {8'h00, d[7:0]};
        wait_cyc(1);
        i_tsmar_host.xfer(WIDE[a] ? {cmd, d} : {cmd, d[7:0], 8'h00}, WIDE[a] ? 24 : 16, rx);
        if (!WIDE[a]) rx = {8'h00, rx[7:0]};
    endtask : acc
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    initial begin
        #1000000;
        num_errors++;
        results();
    end
    initial begin
        w = 16'($urandom(60984));
        wait_cyc(8);
        nrst = 1'b1;
        for (int p = 0; p < 2; p++) begin
            for (int a = 1; a < 8; a++) begin
                if (p && a inside {2, 3, 5}) acc(1'b0, 3'(a), 16'($urandom_range(3)));
                if (a != 2) begin
                    acc(1'b1, 3'(a), 16'h0000);
                    chk(rx, regs[a]);
                end
            end
        end
        $display("register test done");
        for (int res = 0; res < 2; res++) begin
            acc(1'b0, 3'h1, 16'(res << 7));
            repeat (3) begin
                wait_cyc(1);
                code = 16'($urandom);
                w = fmt(code);
                // flush flags left by the previous code before the status compare
                acc(1'b1, 3'h0, 16'h0000);
                acc(1'b1, 3'h2, 16'h0000);
                chk(rx, w);
                if (res == 0) chk({7'h00, rx[15:7]}, {7'h00, code[15:7]});
                if (res == 0) deg = 8 * (rx[15] ? int'(rx[15:3]) - 8192 : int'(rx[15:3]));
                else deg = rx[15] ? int'(rx) - 65536 : int'(rx);
                chk(16'(deg), res ? code : code & 16'hFFF8);
                acc(1'b1, 3'h0, 16'h0000);
                if (res == 0) chk(rx, {8'h00, 1'b0, w[2:0], 4'h0});
            end
        end
        $display("format test done");
        acc(1'b0, 3'h1, 16'h0000);
        code = 16'h3000;
        acc(1'b0, 3'h1, 16'h0060);
        w = fmt(code);
        code = 16'h0100;
        acc(1'b1, 3'h2, 16'h0000);
        chk(rx, w);
        acc(1'b1, 3'h0, 16'h0000);
        chk(rx, {8'h00, 1'b1, w[2:0], 4'h0});
        acc(1'b1, 3'h0, 16'h0000);
        chk(rx, 16'h0080);
        acc(1'b0, 3'h1, 16'h0000);
        acc(1'b1, 3'h2, 16'h0000);
        chk(rx, fmt(code));
        $display("shutdown test done");
        for (int fq = 0; fq < 4; fq++) begin
            code = 16'h1000;
            acc(1'b0, 3'h1, 16'(8'h10 + fq));
            wait_cyc(3 * CONV);
            code = 16'h5000;
            wait_cyc(fq * CONV - 2);
            chk({14'h0, ct_oe, lim_oe}, 16'h0000);
            wait_cyc(CONV + 8);
            chk({14'h0, ct_oe, lim_oe}, 16'h0003);
        end
        acc(1'b0, 3'h1, 16'h001F);
        chk({14'h0, ct_oe, lim_oe}, 16'h0000);
        acc(1'b0, 3'h1, 16'h0003);
        code = 16'h1000;
        wait_cyc(2 * CONV);
        chk({14'h0, ct_oe, lim_oe}, 16'h0003);
        acc(1'b1, 3'h5, 16'h0000);
        chk({14'h0, ct_oe, lim_oe}, 16'h0000);
        $display("alarm test done");
        results();
    end
endmodule : tb
`default_nettype wire

// ==== tb/tsmar_checker.sv ====
// checker: select, miso enable and alarm pin timing at the core ports
// assumes binding into tsmar_top with its conversion length
`default_nettype none
module tsmar_checker #(
    parameter int unsigned CONV_CONT_CYC = 40
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_cs_n,
    input wire logic o_miso_oe,
    input wire logic o_critical_alarm_out,
    input wire logic o_critical_alarm_out_oe,
    input wire logic o_limit_alarm_out,
    input wire logic o_limit_alarm_out_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    logic [7:0] age_q;
    // ====================
    // cycles since reset release
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) age_q <= 8'h00;
        else if (age_q != 8'hFF) age_q <= age_q + 8'h01;
    end
    AST_CT_DATA: assert property (!o_critical_alarm_out)
        else $error("critical pin data high");
    AST_LIM_DATA: assert property (!o_limit_alarm_out)
        else $error("limit pin data high");
    AST_OE_SEL: assert property ($rose(o_miso_oe) |-> !i_cs_n)
        else $error("miso enabled unselected");
    AST_OE_IDLE: assert property (i_cs_n [*6] |-> !o_miso_oe)
        else $error("miso enabled while idle");
    AST_OE_REL: assert property ($rose(i_cs_n) |-> ##[1:5] !o_miso_oe)
        else $error("miso not released");
    AST_OE_CMD: assert property ($fell(i_cs_n) |=> !o_miso_oe [*8])
        else $error("miso enabled in command");
    AST_FIRST: assert property (age_q < 8'(CONV_CONT_CYC / 2)
        |-> !o_limit_alarm_out_oe && !o_critical_alarm_out_oe) else $error("alarm too early");
    AST_LIM_GAP: assert property (i_cs_n [*8] ##0 $changed(o_limit_alarm_out_oe)
        |=> $stable(o_limit_alarm_out_oe) [*8]) else $error("limit alarm changed twice");
endmodule : tsmar_checker
bind tsmar_top tsmar_checker #(.CONV_CONT_CYC(CONV_CONT_CYC)) i_tsmar_checker (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_cs_n(i_cs_n), .o_miso_oe(o_miso_oe),
    .o_critical_alarm_out(o_critical_alarm_out),
    .o_critical_alarm_out_oe(o_critical_alarm_out_oe),
    .o_limit_alarm_out(o_limit_alarm_out), .o_limit_alarm_out_oe(o_limit_alarm_out_oe));
`default_nettype wire

// ==== tb/tsmar_host.sv ====
// host model: serial master, mode 3, msb first, clock still between frames
// assumes the core oversamples the pins on its own clock
`default_nettype none
module tsmar_host (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // ====================
    // one whole frame of nbits from the top of tx, 80 ns period
    task automatic xfer(input logic [23:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        #3;
        o_cs_n = 1'b0;
        #40;
        for (int i = 23; i > 23 - nbits; i--) begin
            o_sclk = 1'b0;
            o_mosi = tx[i];
            #40;
            o_sclk = 1'b1;
            #20;
            rx = {rx[14:0], i_miso};
            #20;
        end
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        #80;
    endtask : xfer
endmodule : tsmar_host
`default_nettype wire
